// file: shared/isp_pkg.sv
// constants, state type and address decode for the serial register port
package isp_pkg;

  // selectable own addresses, indexed by the two-bit fuse option
  localparam logic [6:0] ADDR_OPT0      = 7'h1E;
  localparam logic [6:0] ADDR_OPT1      = 7'h24;
  localparam logic [6:0] ADDR_OPT2      = 7'h37;
  localparam logic [6:0] ADDR_OPT3      = 7'h77;
  localparam logic [6:0] GENERAL_CALL   = 7'h00;
  // high-speed master code is 0000_1xx
  localparam logic [4:0] HS_CODE_PREFIX = 5'h01;

  // bit positions inside a nine-bit frame
  localparam logic [3:0] FIRST_BIT      = 4'h0;
  localparam logic [3:0] LAST_DATA_BIT  = 4'h7;
  localparam logic [3:0] ACK_BIT        = 4'h8;

  // reset values
  localparam logic [7:0] PTR_RESET      = 8'h00;
  localparam logic [7:0] BYTE_RESET     = 8'h00;
  localparam logic [6:0] ADDR_RESET     = 7'h00;

  // positions in the vector carried across into the system clock domain
  localparam int SY_WR    = 0;
  localparam int SY_RD    = 1;
  localparam int SY_HS    = 2;
  localparam int SY_STOP  = 3;
  localparam int SY_BIAS  = 4;
  localparam int SY_TURN  = 5;
  localparam int SY_FUSE  = 6;
  localparam int SY_WIDTH = 8;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_ADDR  = 5'h02,
    ST_PTR   = 5'h04,
    ST_WDATA = 5'h08,
    ST_RDATA = 5'h10
  } isp_state_t;

  function automatic logic [6:0] isp_own_addr(input logic [1:0] opt);
    case (opt)
      2'h0:    isp_own_addr = ADDR_OPT0;
      2'h1:    isp_own_addr = ADDR_OPT1;
      2'h2:    isp_own_addr = ADDR_OPT2;
      default: isp_own_addr = ADDR_OPT3;
    endcase
  endfunction : isp_own_addr

endpackage : isp_pkg

// file: shared/isp_cond_if.sv
// bus line levels and START/STOP flags shared by the port and its detector
`timescale 1ns/1ns
interface isp_cond_if;
  logic scl;
  logic sda;
  logic link_rst;
  logic start_det;
  logic stop_det;

  modport det (
    input  scl,
    input  sda,
    input  link_rst,
    output start_det,
    output stop_det
  );

  modport eng (
    output scl,
    output sda,
    output link_rst,
    input  start_det,
    input  stop_det
  );
endinterface : isp_cond_if

// file: hdl/isp_cond_det.sv
// START and STOP condition detector clocked by the data line edges
`timescale 1ns/1ns
module isp_cond_det (
  isp_cond_if.det cd
);

  logic start_q;
  logic stop_q;
  logic start_seen;
  wire  start_clr = cd.link_rst | start_seen;
  wire  stop_clr  = cd.link_rst | start_q;

  // data falling while clock high
  always_ff @(negedge cd.sda or posedge start_clr) begin
    if (start_clr) begin
      start_q <= 1'b0;
    end else begin
      start_q <= cd.scl; // RULE8
    end
  end

  // the engine sees the flag on the first clock fall, then it is dropped
  always_ff @(negedge cd.scl or posedge cd.link_rst) begin
    if (cd.link_rst) begin
      start_seen <= 1'b0;
    end else begin
      start_seen <= start_q;
    end
  end

  // data rising while clock high; held until the next START
  always_ff @(posedge cd.sda or posedge stop_clr) begin
    if (stop_clr) begin
      stop_q <= 1'b0;
    end else begin
      stop_q <= cd.scl; // RULE8
    end
  end

  assign cd.start_det = start_q;
  assign cd.stop_det  = stop_q;

endmodule : isp_cond_det

// file: hdl/isp_slave_port.sv
// two-wire slave port giving a bus master access to 8-bit registers
//
// Functional notes
// RULE1: slave only, any clock rate to 3.4MHz
// RULE2: match 7-bit address after START
// RULE3: no acknowledge for foreign addresses
// RULE4: 8-bit registers chosen by 8-bit pointer
// RULE5: single and burst writes and reads
// RULE6: never holds the clock line low
// RULE7: one bit per clock, change while low
// RULE8: START and STOP from data edges, clock high
// RULE9: eight bits MSB first, then acknowledge
// RULE10: lines released when idle
// RULE11: repeated START restarts address reception
// RULE12: ignore clocks after STOP or mismatch
// RULE13: acknowledge drives data low over ninth clock
// RULE14: no acknowledge leaves data released
// RULE15: receiver drives the acknowledge bit
// RULE16: master ends with no acknowledge, STOP
// RULE17: master may chain with repeated STARTs
// RULE18: acknowledge every pointer value
// RULE19: active only while logic supply on
// RULE20: shut down means both lines released
// RULE21: master retries after missing acknowledge
// RULE22: fuse option selects one of four addresses
// RULE23: general call address not acknowledged
// RULE24: STOP leaves pointer unchanged
// RULE25: slow filtering after reset and STOP
// RULE26: pointer increments per byte, wraps
`timescale 1ns/1ns
module isp_slave_port (
  input  wire logic       MCLK,
  input  wire logic       RESET,
  input  wire logic       SCL_IN,
  output wire logic       SCL_OUT,
  output wire logic       SCL_OE,
  input  wire logic       SDA_IN,
  output wire logic       SDA_OUT,
  output wire logic       SDA_OE,
  input  wire logic       BIAS_TURN_ON_PIN,
  input  wire logic       TURN_ON,
  input  wire logic [1:0] ADDRESS_OPTION_FUSE,
  output logic            LINK_ON,
  output logic            HS_FILTER,
  output logic            WR_VALID,
  output logic      [7:0] WR_PTR,
  output logic      [7:0] WR_DATA,
  output logic            RD_REQ,
  output logic      [7:0] RD_PTR,
  input  wire logic [7:0] RD_DATA
);

  // ------------------------------------------------------------------
  // system clock side: supply state, fuse, reset of the link logic
  // ------------------------------------------------------------------
  logic [isp_pkg::SY_WIDTH-1:0] sync1;
  logic [isp_pkg::SY_WIDTH-1:0] sync2;
  logic [isp_pkg::SY_WIDTH-1:0] sync_in;
  logic [2:0]                   tgl_prev;
  logic                         link_rst;
  logic [6:0]                   own_addr;
  logic [7:0]                   rd_word;

  // link side state, declared here so the crossing vector can name it
  logic                         wr_tgl;
  logic                         rd_tgl;
  logic                         hs_tgl;
  logic [7:0]                   wr_ptr_q;
  logic [7:0]                   wr_data_q;
  logic [7:0]                   rd_ptr_q;

  isp_cond_if cd ();

  assign cd.scl      = SCL_IN;
  assign cd.sda      = SDA_IN;
  assign cd.link_rst = link_rst;

  isp_cond_det u_cond (
    .cd (cd)
  );

  assign sync_in = {ADDRESS_OPTION_FUSE, TURN_ON, BIAS_TURN_ON_PIN,
                    cd.stop_det, hs_tgl, rd_tgl, wr_tgl};

  // two-stage synchroniser for every level and toggle entering MCLK
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= sync_in;
      sync2 <= sync1;
    end
  end

  wire supply_on = sync2[isp_pkg::SY_BIAS] | sync2[isp_pkg::SY_TURN];
  wire stop_seen = sync2[isp_pkg::SY_STOP];
  // toggles cleared by shutdown must not look like events
  wire wr_fire   = (sync2[isp_pkg::SY_WR] ^ tgl_prev[0]) & ~link_rst;
  wire rd_fire   = (sync2[isp_pkg::SY_RD] ^ tgl_prev[1]) & ~link_rst;
  wire hs_fire   = (sync2[isp_pkg::SY_HS] ^ tgl_prev[2]) & ~link_rst;
  wire [1:0] fuse_opt = sync2[isp_pkg::SY_FUSE +: 2];

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      tgl_prev <= 3'h0;
      link_rst <= 1'b1;
      LINK_ON  <= 1'b0;
      own_addr <= isp_pkg::ADDR_RESET;
    end else begin
      tgl_prev <= sync2[isp_pkg::SY_HS:isp_pkg::SY_WR];
      link_rst <= ~supply_on; // RULE19
      LINK_ON  <= supply_on; // RULE19
      own_addr <= isp_pkg::isp_own_addr(fuse_opt); // RULE22
    end
  end

  // write and read requests toward the register owner
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      WR_VALID <= 1'b0;
      WR_PTR   <= isp_pkg::PTR_RESET;
      WR_DATA  <= isp_pkg::BYTE_RESET;
      RD_REQ   <= 1'b0;
      RD_PTR   <= isp_pkg::PTR_RESET;
    end else begin
      WR_VALID <= wr_fire; // RULE5
      RD_REQ   <= rd_fire; // RULE5
      if (wr_fire) begin
        WR_PTR  <= wr_ptr_q;
        WR_DATA <= wr_data_q;
      end
      if (rd_fire) begin
        RD_PTR <= rd_ptr_q;
      end
    end
  end

  // read data is taken in the cycle that the request stands
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      rd_word <= isp_pkg::BYTE_RESET;
    end else if (RD_REQ) begin
      rd_word <= RD_DATA; // RULE4
    end
  end

  // input filter selection; the master code sets, STOP clears
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      HS_FILTER <= 1'b0; // RULE25
    end else if (hs_fire) begin
      HS_FILTER <= 1'b1;
    end else if (stop_seen) begin
      HS_FILTER <= 1'b0; // RULE25
    end
  end

  // ------------------------------------------------------------------
  // link side, clocked by the bus clock
  // ------------------------------------------------------------------
  isp_pkg::isp_state_t state;
  isp_pkg::isp_state_t next_state;
  logic [3:0]          cnt;
  logic [3:0]          next_cnt;
  logic [7:0]          rx;
  logic [7:0]          tx;
  logic [7:0]          next_tx;
  logic [7:0]          ptr;
  logic [7:0]          next_ptr;
  logic                rw;
  logic                next_rw;
  logic                drv;
  logic                next_drv;
  logic                next_wr_evt;
  logic                next_rd_evt;
  logic                next_hs_evt;

  // sample on the rising clock, most significant bit first
  always_ff @(posedge SCL_IN or posedge link_rst) begin
    if (link_rst) begin
      rx <= isp_pkg::BYTE_RESET;
    end else begin
      rx <= {rx[6:0], SDA_IN}; // RULE7 RULE9
    end
  end

  wire at_last   = (cnt == isp_pkg::LAST_DATA_BIT);
  wire at_ack    = (cnt == isp_pkg::ACK_BIT);
  wire [3:0] cnt_inc = cnt + 4'h1;
  wire [7:0] ptr_inc = ptr + 8'h01; // RULE26
  wire is_gcall  = (rx[7:1] == isp_pkg::GENERAL_CALL);
  wire is_hscode = (rx[7:3] == isp_pkg::HS_CODE_PREFIX);
  wire addr_hit  = (rx[7:1] == own_addr) & ~is_gcall; // RULE2 RULE3 RULE23
  wire master_nack = rx[0];

  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_tx     = tx;
    next_ptr    = ptr;
    next_rw     = rw;
    next_drv    = 1'b0;
    next_wr_evt = 1'b0;
    next_rd_evt = 1'b0;
    next_hs_evt = 1'b0;
    if (cd.start_det) begin
      next_state = isp_pkg::ST_ADDR; // RULE11
      next_cnt   = isp_pkg::FIRST_BIT;
    end else if (cd.stop_det) begin
      next_state = isp_pkg::ST_IDLE; // RULE12 RULE24
    end else begin
      case (state)
        isp_pkg::ST_IDLE: begin
          next_cnt = isp_pkg::FIRST_BIT; // RULE12
        end
        isp_pkg::ST_ADDR: begin
          if (at_last) begin
            next_rw = rx[0];
            if (addr_hit) begin
              next_drv = 1'b1; // RULE13 RULE15
              next_cnt = isp_pkg::ACK_BIT;
            end else begin
              next_hs_evt = is_hscode;
              next_state  = isp_pkg::ST_IDLE; // RULE3 RULE12 RULE14
            end
          end else if (at_ack) begin
            next_cnt = isp_pkg::FIRST_BIT;
            if (rw) begin
              next_state = isp_pkg::ST_RDATA;
              next_tx    = rd_word;
              next_drv   = ~rd_word[7]; // RULE9
            end else begin
              next_state = isp_pkg::ST_PTR;
            end
          end else begin
            next_cnt = cnt_inc;
          end
        end
        isp_pkg::ST_PTR: begin
          if (at_last) begin
            next_ptr    = rx; // RULE4
            next_rd_evt = 1'b1;
            next_drv    = 1'b1; // RULE18
            next_cnt    = isp_pkg::ACK_BIT;
          end else if (at_ack) begin
            next_cnt   = isp_pkg::FIRST_BIT;
            next_state = isp_pkg::ST_WDATA;
          end else begin
            next_cnt = cnt_inc;
          end
        end
        isp_pkg::ST_WDATA: begin
          if (at_last) begin
            next_wr_evt = 1'b1; // RULE5
            next_ptr    = ptr_inc; // RULE26
            next_rd_evt = 1'b1;
            next_drv    = 1'b1; // RULE13 RULE15
            next_cnt    = isp_pkg::ACK_BIT;
          end else if (at_ack) begin
            next_cnt = isp_pkg::FIRST_BIT;
          end else begin
            next_cnt = cnt_inc;
          end
        end
        isp_pkg::ST_RDATA: begin
          if (at_last) begin
            next_ptr    = ptr_inc; // RULE26
            next_rd_evt = 1'b1;
            next_cnt    = isp_pkg::ACK_BIT; // RULE15
          end else if (at_ack) begin
            next_cnt = isp_pkg::FIRST_BIT;
            if (master_nack) begin
              next_state = isp_pkg::ST_IDLE; // RULE16
            end else begin
              next_tx  = rd_word; // RULE5
              next_drv = ~rd_word[7];
            end
          end else begin
            next_cnt = cnt_inc;
            next_tx  = {tx[6:0], 1'b0};
            next_drv = ~tx[6]; // RULE7 RULE9
          end
        end
        default: begin
          next_state = isp_pkg::ST_IDLE;
          next_cnt   = isp_pkg::FIRST_BIT;
        end
      endcase
    end
  end

  // state and data line drive change only on the falling clock
  always_ff @(negedge SCL_IN or posedge link_rst) begin
    if (link_rst) begin
      state <= isp_pkg::ST_IDLE;
      cnt   <= isp_pkg::FIRST_BIT;
      tx    <= isp_pkg::BYTE_RESET;
      ptr   <= isp_pkg::PTR_RESET;
      rw    <= 1'b0;
      drv   <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      tx    <= next_tx;
      ptr   <= next_ptr;
      rw    <= next_rw;
      drv   <= next_drv; // RULE7
    end
  end

  // events toward MCLK: payload loaded on the same clock fall that the toggle flips
  always_ff @(negedge SCL_IN or posedge link_rst) begin
    if (link_rst) begin
      wr_tgl    <= 1'b0;
      rd_tgl    <= 1'b0;
      hs_tgl    <= 1'b0;
      wr_ptr_q  <= isp_pkg::PTR_RESET;
      wr_data_q <= isp_pkg::BYTE_RESET;
      rd_ptr_q  <= isp_pkg::PTR_RESET;
    end else begin
      if (next_wr_evt) begin
        wr_tgl    <= ~wr_tgl;
        wr_ptr_q  <= ptr;
        wr_data_q <= rx;
      end
      if (next_rd_evt) begin
        rd_tgl   <= ~rd_tgl;
        rd_ptr_q <= next_ptr;
      end
      if (next_hs_evt) begin
        hs_tgl <= ~hs_tgl;
      end
    end
  end

  // ------------------------------------------------------------------
  // pins: open drain, clock never driven
  // ------------------------------------------------------------------
  assign SCL_OUT = 1'b0;
  assign SCL_OE  = 1'b0; // RULE1 RULE6
  assign SDA_OUT = 1'b0;
  // released when off, idle or after STOP
  assign SDA_OE  = drv & ~link_rst & ~cd.stop_det; // RULE10 RULE20

endmodule : isp_slave_port

// file: test/isp_chk.sv
// concurrent checks on the pins of the serial register port
`timescale 1ns/1ns
module isp_chk (
  input wire logic       MCLK,
  input wire logic       RESET,
  input wire logic       SCL_IN,
  input wire logic       SCL_OUT,
  input wire logic       SCL_OE,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE,
  input wire logic       BIAS_TURN_ON_PIN,
  input wire logic       TURN_ON,
  input wire logic       LINK_ON,
  input wire logic       WR_VALID,
  input wire logic [7:0] WR_PTR,
  input wire logic [7:0] WR_DATA,
  input wire logic       RD_REQ,
  input wire logic [7:0] RD_PTR
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  sequence s_on4;
    (BIAS_TURN_ON_PIN || TURN_ON) [*4];
  endsequence
  sequence s_off4;
    (!BIAS_TURN_ON_PIN && !TURN_ON) [*4];
  endsequence
  sequence s_quiet_wr;
    !WR_VALID [*8];
  endsequence
  sequence s_quiet_rd;
    !RD_REQ [*8];
  endsequence
  property p_scl;
    !SCL_OE && !SCL_OUT && !SDA_OUT;
  endproperty
  property p_on;
    s_on4 |=> LINK_ON;
  endproperty
  property p_off;
    s_off4 |=> !LINK_ON;
  endproperty
  property p_oe_off;
    !LINK_ON |-> !SDA_OE;
  endproperty
  property p_rise;
    $rose(SDA_OE) |-> !SCL_IN;
  endproperty
  property p_fell;
    $fell(SDA_OE) && LINK_ON |-> !SCL_IN;
  endproperty
  property p_wr;
    WR_VALID |=> s_quiet_wr;
  endproperty
  property p_rd;
    RD_REQ |=> s_quiet_rd;
  endproperty
  property p_hold;
    !WR_VALID |-> $stable(WR_PTR) && $stable(WR_DATA);
  endproperty
  property p_rdhold;
    !RD_REQ |-> $stable(RD_PTR);
  endproperty
  a_scl: assert property (p_scl) else $error("bus line driven");
  a_on: assert property (p_on) else $error("link not on");
  a_off: assert property (p_off) else $error("link not off");
  a_oe_off: assert property (p_oe_off) else $error("oe when off");
  a_rise: assert property (p_rise) else $error("oe rose high");
  a_fell: assert property (p_fell) else $error("oe fell high");
  a_wr: assert property (p_wr) else $error("write pulse long");
  a_rd: assert property (p_rd) else $error("read pulse long");
  a_hold: assert property (p_hold) else $error("write moved");
  a_rdhold: assert property (p_rdhold) else $error("read moved");
endmodule : isp_chk
bind isp_slave_port isp_chk u_chk (
  .MCLK(MCLK), .RESET(RESET), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT),
  .SCL_OE(SCL_OE), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .BIAS_TURN_ON_PIN(BIAS_TURN_ON_PIN), .TURN_ON(TURN_ON),
  .LINK_ON(LINK_ON), .WR_VALID(WR_VALID), .WR_PTR(WR_PTR),
  .WR_DATA(WR_DATA), .RD_REQ(RD_REQ), .RD_PTR(RD_PTR)
);

// file: test/isp_mst.sv
// behavioural bus master that makes the clock and pulls the data line
`timescale 1ns/1ns
module isp_mst #(
  parameter int Q = 100
) (
  input  wire logic sda,
  output logic      scl,
  output logic      pull
);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic start();
    pull = 1'b0;
    #Q scl = 1'b1;
    #Q pull = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask : start
  task automatic stop();
    pull = 1'b1;
    #Q scl = 1'b1;
    #Q pull = 1'b0;
    #Q;
  endtask : stop
  task automatic clk(output logic s);
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : clk
  task automatic wb(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pull = !b[i];
      clk(s);
    end
    pull = 1'b0;
    clk(s);
    ack = !s;
  endtask : wb
  task automatic rb(input logic last, output logic [7:0] b);
    logic s;
    pull = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      clk(s);
      b[i] = s;
    end
    pull = !last;
    clk(s);
  endtask : rb
endmodule : isp_mst

// file: test/tb_top.sv
// self-checking bench for the serial register port
`timescale 1ns/1ns
`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    $display("wrong value at %0t: got %h exp %h", $time, g, e); \
    failures++; \
  end \
end
module tb_top;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        bias = 1'b1;
  logic        turn = 1'b0;
  logic [1:0]  fuse = 2'h0;
  logic        scl;
  logic        pull;
  logic        scl_oe;
  logic        sda_oe;
  logic        link_on;
  logic        hs;
  logic        wr_valid;
  logic [7:0]  wr_ptr;
  logic [7:0]  wr_data;
  logic        rd_req;
  logic [7:0]  rd_ptr;
  logic [7:0]  mem [256];
  logic [7:0]  em [256];
  logic [15:0] wq [$];
  logic [31:0] seed = 32'h6051B03C;
  logic [6:0]  own [4] = '{isp_pkg::ADDR_OPT0, isp_pkg::ADDR_OPT1,
                           isp_pkg::ADDR_OPT2, isp_pkg::ADDR_OPT3};
  int          failures = 0;
  int          cmp_count = 0;
  wire         sda = !(pull || sda_oe);
  wire         scl_in = scl && !scl_oe;
  initial begin
    forever #20 mclk = !mclk;
  end
  isp_mst u_mst (.sda(sda), .scl(scl), .pull(pull));
  isp_slave_port u_dut (
    .MCLK(mclk), .RESET(rst), .SCL_IN(scl_in), .SCL_OUT(),
    .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe),
    .BIAS_TURN_ON_PIN(bias), .TURN_ON(turn),
    .ADDRESS_OPTION_FUSE(fuse), .LINK_ON(link_on), .HS_FILTER(hs),
    .WR_VALID(wr_valid), .WR_PTR(wr_ptr), .WR_DATA(wr_data),
    .RD_REQ(rd_req), .RD_PTR(rd_ptr), .RD_DATA(mem[rd_ptr])
  );
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  always @(posedge mclk) begin : wr_mon
    logic [15:0] exp_w;
    if (wr_valid) begin
      mem[wr_ptr] <= wr_data;
      exp_w = wq.size() ? wq.pop_front() : 16'hXXXX;
      `CHK({wr_ptr, wr_data}, exp_w)
    end
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] p,
                    input int n, input logic ok);
    logic       k;
    logic [7:0] d;
    u_mst.start();
    u_mst.wb({a, 1'b0}, k);
    `CHK(k, ok)
    u_mst.wb(p, k);
    `CHK(k, ok)
    for (int i = 0; i < n; i++) begin
      d = rnd();
      if (ok) wq.push_back({p, d});
      if (ok) em[p] = d;
      u_mst.wb(d, k);
      `CHK(k, ok)
      p++;
    end
    u_mst.stop();
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] p,
                    input int n, input logic setp);
    logic       k;
    logic [7:0] d;
    u_mst.start();
    if (setp) u_mst.wb({a, 1'b0}, k);
    if (setp) u_mst.wb(p, k);
    if (setp) u_mst.start();
    u_mst.wb({a, 1'b1}, k);
    `CHK(k, 1'b1)
    for (int i = 0; i < n; i++) begin
      u_mst.rb(i == n - 1, d);
      `CHK(d, em[p])
      p++;
    end
    u_mst.stop();
  endtask : rd
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  initial begin
    #1000000;
    failures++;
    conclude();
  end
  initial begin
    logic k;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hC3;
    for (int i = 0; i < 256; i++) em[i] = 8'(i) ^ 8'hC3;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    `CHK(link_on, 1'b1)
    `CHK(sda, 1'b1)
    `CHK(hs, 1'b0)
    for (int o = 0; o < 4; o++) begin
      @(posedge mclk) fuse <= 2'(o);
      wr(own[o], 8'(o), 1, 1'b1);
      wr(own[(o + 1) % 4], 8'h10, 2, 1'b0);
    end
    $display("test address options done");
    wr(isp_pkg::GENERAL_CALL, 8'h00, 1, 1'b0);
    $display("test general call done");
    wr(own[3], 8'hFE, 3, 1'b1);
    $display("test burst write done");
    rd(own[3], 8'hFE, 3, 1'b1);
    rd(own[3], 8'h01, 1, 1'b0);
    $display("test reads done");
    u_mst.start();
    u_mst.wb(8'h08, k);
    `CHK(k, 1'b0)
    `CHK(hs, 1'b1)
    u_mst.stop();
    repeat (8) @(posedge mclk);
    `CHK(hs, 1'b0)
    $display("test master code done");
    @(posedge mclk) bias <= 1'b0;
    repeat (8) @(posedge mclk);
    `CHK(link_on, 1'b0)
    wr(own[3], 8'h00, 1, 1'b0);
    @(posedge mclk) turn <= 1'b1;
    repeat (8) @(posedge mclk);
    `CHK(link_on, 1'b1)
    wr(own[3], 8'h00, 2, 1'b1);
    rd(own[3], 8'h00, 2, 1'b1);
    repeat (20) @(posedge mclk);
    `CHK(wq.size(), 0)
    $display("test supply done");
    conclude();
  end
endmodule : tb_top
